// *** input_terminal_function_decoder.sv ***
// Multi-function input terminal decoder producing drive commands
module input_terminal_function_decoder
	import input_term_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
	input wire logic clk_sys_i, // System clock, 10 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic input_term_a_i, // Terminal a pin
	input wire logic input_term_b_i, // Terminal b pin
	input wire logic input_term_c_i, // Terminal c pin
	input wire logic input_term_d_i, // Terminal d pin
	input wire logic input_term_e_i, // Terminal e pin
	input wire logic input_term_f_i, // Terminal f pin
	input wire logic [FUNC_W-1:0] term_a_func_sel_i, // Function code of terminal a
	input wire logic [FUNC_W-1:0] term_b_func_sel_i, // Function code of terminal b
	input wire logic [FUNC_W-1:0] term_c_func_sel_i, // Function code of terminal c
	input wire logic [FUNC_W-1:0] term_d_func_sel_i, // Function code of terminal d
	input wire logic [FUNC_W-1:0] term_e_func_sel_i, // Function code of terminal e
	input wire logic [FUNC_W-1:0] term_f_func_sel_i, // Function code of terminal f
	input wire logic [1:0] command_source_sel_i, // Command source, 1 = terminals
	input wire logic running_i, // Drive output is active
	input wire logic [FREQ_W-1:0] main_freq_setting_i, // Main frequency, 0.1 Hz
	input wire logic [FREQ_W-1:0] inch_freq_param_i, // Jog frequency, 0.1 Hz
	input wire logic [FREQ_W-1:0] lower_freq_limit_i, // Lower frequency limit
	input wire logic [FREQ_W-1:0] max_freq_i, // Maximum operating frequency
	input wire logic [FREQ_W-1:0] freq_ii_i, // High speed frequency
	input wire logic [FREQ_W-1:0] freq_iii_i, // Medium speed frequency
	input wire logic [FREQ_W-1:0] freq_iv_i, // Low speed frequency
	input wire logic [TIMER_W-1:0] timer1_preset_i, // Timer one length, ms
	input wire logic [TIMER_W-1:0] timer2_preset_i, // Timer two length, ms
	output logic run_cmd_o, // Run request
	output logic ccw_rotation_cmd_o, // Reverse direction
	output logic jog_active_o, // Jog in progress
	output logic output_cut_o, // Immediate output stop, one cycle
	output logic [1:0] accel_sel_o, // Acceleration time index 0..3
	output logic [3:0] speed_seg_o, // Sixteen-segment speed address
	output logic [1:0] preset_speed_sel_o, // 0 none, 1 low, 2 medium, 3 high
	output logic force_main_o, // Main setting forced
	output logic [FREQ_W-1:0] freq_ref_o, // Frequency reference, 0.1 Hz
	output logic overheat_fault_o, // Overheat input active
	output logic ext_fault_o, // External cut-off fault active
	output logic fault_reset_o, // Fault reset, one cycle
	output logic closed_loop_ctrl_o, // Closed-loop control enabled
	output logic wobble_en_o, // Wobble function permitted
	output logic freq_up_step_o, // Raise frequency one unit, one cycle
	output logic freq_down_step_o, // Lower frequency one unit, one cycle
	output logic timer1_done_o, // Timer one expired
	output logic timer2_done_o, // Timer two expired
	output logic [COUNT_W-1:0] pulse_count_o, // Pulse counter value
	output logic cleared_count_display_o // Count has been cleared
);

	function automatic logic [FREQ_W-1:0] clamp(input logic [FREQ_W-1:0] v,
		input logic [FREQ_W-1:0] lo, input logic [FREQ_W-1:0] hi);
		if (v > hi)
			return hi;
		else if (v < lo)
			return lo;
		else
			return v;
	endfunction

	logic [NUM_TERMS-1:0] pin_raw;
	logic [NUM_TERMS-1:0] pin_meta;
	logic [NUM_TERMS-1:0] pin_sync;
	logic [NUM_TERMS-1:0] pin_stable;
	logic [DB_W-1:0] db_cnt [NUM_TERMS];
	logic [FUNC_W-1:0] sel [NUM_TERMS];
	logic [NUM_CODES-1:0] act;
	logic [NUM_CODES-1:0] act_q;
	logic [NUM_CODES-1:0] rise;
	logic three_wire;
	logic term_src;
	logic fault;
	logic [15:0] ms_cnt;
	logic ms_tick;
	logic tw_run;
	logic tw_dir;
	logic jog_req;
	logic jog_dir;
	logic run2;
	logic dir2;
	logic next_run;
	logic next_dir;
	logic [1:0] next_accel;
	logic [1:0] next_preset;
	logic [FREQ_W-1:0] next_freq;
	logic ud_up;
	logic ud_dn;
	logic ud_on;
	logic ud_on_q;
	logic [15:0] ud_ms;
	logic [7:0] ud_fast_n;
	logic [15:0] ud_limit;
	logic [TIMER_W-1:0] tmr_cnt [2];
	logic [1:0] tmr_run;
	logic [1:0] tmr_done;

	assign pin_raw = {input_term_f_i, input_term_e_i, input_term_d_i,
		input_term_c_i, input_term_b_i, input_term_a_i};
	assign sel[0] = term_a_func_sel_i;
	assign sel[1] = term_b_func_sel_i;
	assign sel[2] = term_c_func_sel_i;
	assign sel[3] = term_d_func_sel_i;
	assign sel[4] = term_e_func_sel_i;
	assign sel[5] = term_f_func_sel_i;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= pin_raw; // RULE_23
			pin_sync <= pin_meta;
		end
	end

	// Short debounce keeps 2 ms pulses at 250 Hz intact
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_stable <= '0;
			for (int i = 0; i < NUM_TERMS; i++)
				db_cnt[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_TERMS; i++)
			begin
				if (pin_sync[i] == pin_stable[i])
					db_cnt[i] <= '0;
				else if (db_cnt[i] == DB_W'(DEBOUNCE_CYCLES - 1))
				begin
					pin_stable[i] <= pin_sync[i]; // RULE_23
					db_cnt[i] <= '0;
				end
				else
					db_cnt[i] <= db_cnt[i] + 1'b1;
			end
		end
	end

	// Several terminals may share a code; their levels are ORed
	always_comb
	begin
		act = '0;
		three_wire = 1'b0;
		for (int i = 0; i < NUM_TERMS; i++)
		begin
			if (sel[i] <= FN_MAX && pin_stable[i])
				act[sel[i]] = 1'b1; // RULE_01
			if (sel[i] == FN_STOP)
				three_wire = 1'b1; // RULE_19
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			act_q <= '0;
		else
			act_q <= act;
	end

	assign rise = act & ~act_q;
	assign term_src = (command_source_sel_i == TERM_SRC);
	assign fault = act[FN_OVERHEAT] | act[FN_EXT_FAULT];

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ms_cnt <= '0;
			ms_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= (ms_cnt == 16'(MS_TICK_CYCLES - 1));
			if (ms_cnt == 16'(MS_TICK_CYCLES - 1))
				ms_cnt <= '0;
			else
				ms_cnt <= ms_cnt + 1'b1;
		end
	end

	// Three-wire latch; a held-open stop contact also blocks starting
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tw_run <= 1'b0;
			tw_dir <= 1'b0;
		end
		else if (!three_wire || !term_src || fault || jog_active_o || !act[FN_STOP])
			tw_run <= 1'b0; // RULE_21
		else if (rise[FN_CW])
		begin
			tw_run <= 1'b1; // RULE_21
			tw_dir <= 1'b0;
		end
		else if (rise[FN_CCW])
		begin
			tw_run <= 1'b1; // RULE_21
			tw_dir <= 1'b1;
		end
		else if (rise[FN_TOGGLE])
			tw_dir <= ~tw_dir; // RULE_19
	end

	assign run2 = act[FN_RUN] | act[FN_CW] | act[FN_CCW];
	assign dir2 = (act[FN_CCW] & ~act[FN_CW]) | act[FN_TOGGLE]; // RULE_02

	assign jog_req = act[FN_JOG] | act[FN_JOG_CW] | act[FN_JOG_CCW];

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			jog_active_o <= 1'b0;
			jog_dir <= 1'b0;
			output_cut_o <= 1'b0;
		end
		else
		begin
			output_cut_o <= jog_active_o & ~jog_req; // RULE_05
			if (!jog_req)
				jog_active_o <= 1'b0; // RULE_05
			else if (!jog_active_o && !running_i && !run_cmd_o)
			begin
				jog_active_o <= 1'b1; // RULE_06
				jog_dir <= act[FN_JOG_CCW] | (act[FN_JOG] & ~act[FN_JOG_CW] & ccw_rotation_cmd_o);
			end
		end
	end

	always_comb
	begin
		if (act[FN_HIGH])
			next_preset = PRESET_HIGH; // RULE_13
		else if (act[FN_MEDIUM])
			next_preset = PRESET_MED;
		else if (act[FN_LOW])
			next_preset = PRESET_LOW;
		else
			next_preset = PRESET_NONE;
		if (jog_active_o)
		begin
			next_run = 1'b1; // RULE_04
			next_dir = jog_dir;
			next_accel = ACC_JOG; // RULE_04
			next_freq = clamp(inch_freq_param_i, lower_freq_limit_i, max_freq_i); // RULE_07
		end
		else
		begin
			next_run = term_src & ~fault & (three_wire ? tw_run : run2);
			next_dir = three_wire ? tw_dir : dir2;
			next_accel = {act[FN_ACC_SEL1], act[FN_ACC_SEL0]}; // RULE_11
			if (act[FN_FORCE_MAIN])
				next_freq = main_freq_setting_i; // RULE_09
			else
			begin
				unique case (next_preset)
					PRESET_HIGH: next_freq = freq_ii_i;
					PRESET_MED: next_freq = freq_iii_i;
					PRESET_LOW: next_freq = freq_iv_i;
					PRESET_NONE: next_freq = main_freq_setting_i;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_cmd_o <= 1'b0;
			ccw_rotation_cmd_o <= 1'b0;
			accel_sel_o <= '0;
			speed_seg_o <= '0;
			preset_speed_sel_o <= PRESET_NONE;
			force_main_o <= 1'b0;
			freq_ref_o <= '0;
			overheat_fault_o <= 1'b0;
			ext_fault_o <= 1'b0;
			fault_reset_o <= 1'b0;
			closed_loop_ctrl_o <= 1'b0;
			wobble_en_o <= 1'b0;
		end
		else
		begin
			run_cmd_o <= next_run; // RULE_02
			ccw_rotation_cmd_o <= next_dir;
			accel_sel_o <= next_accel;
			speed_seg_o <= jog_active_o ? 4'h0 :
				{act[FN_SEG3], act[FN_SEG2], act[FN_SEG1], act[FN_SEG0]}; // RULE_12
			preset_speed_sel_o <= jog_active_o ? PRESET_NONE : next_preset;
			force_main_o <= act[FN_FORCE_MAIN] & ~jog_active_o;
			freq_ref_o <= next_freq;
			overheat_fault_o <= act[FN_OVERHEAT]; // RULE_10
			ext_fault_o <= act[FN_EXT_FAULT]; // RULE_10
			fault_reset_o <= rise[FN_FAULT_RST]; // RULE_10
			closed_loop_ctrl_o <= act[FN_CLOSED_LOOP] & running_i; // RULE_14
			wobble_en_o <= act[FN_WOBBLE] & ~jog_active_o; // RULE_16
		end
	end

	// Both keys held means no change; stepping only while running
	assign ud_up = act[FN_UP] & ~act[FN_DOWN];
	assign ud_dn = act[FN_DOWN] & ~act[FN_UP];
	assign ud_on = running_i & ~jog_active_o & (ud_up | ud_dn);
	assign ud_limit = (ud_fast_n == 8'h0) ? 16'(UD_HOLD_MS) :
		(ud_fast_n < 8'(UD_FAST_STEPS)) ? 16'(UD_FAST_MS) : 16'(UD_SLOW_MS);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ud_on_q <= 1'b0;
			ud_ms <= '0;
			ud_fast_n <= '0;
			freq_up_step_o <= 1'b0;
			freq_down_step_o <= 1'b0;
		end
		else
		begin
			freq_up_step_o <= 1'b0;
			freq_down_step_o <= 1'b0;
			if (!ud_on)
			begin
				ud_on_q <= 1'b0;
				ud_ms <= '0;
				ud_fast_n <= '0;
			end
			else if (!ud_on_q)
			begin
				ud_on_q <= 1'b1;
				freq_up_step_o <= ud_up; // RULE_15
				freq_down_step_o <= ud_dn;
			end
			else if (ms_tick)
			begin
				if (ud_ms >= ud_limit - 16'h1)
				begin
					ud_ms <= '0;
					freq_up_step_o <= ud_up; // RULE_15
					freq_down_step_o <= ud_dn;
					if (ud_fast_n != 8'(UD_FAST_STEPS))
						ud_fast_n <= ud_fast_n + 1'b1;
				end
				else
					ud_ms <= ud_ms + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tmr_run <= '0;
			tmr_done <= '0;
			tmr_cnt[0] <= '0;
			tmr_cnt[1] <= '0;
		end
		else
		begin
			for (int k = 0; k < 2; k++)
			begin
				if (rise[FN_TIMER1 + k])
				begin
					tmr_cnt[k] <= (k == 0) ? timer1_preset_i : timer2_preset_i; // RULE_08
					tmr_run[k] <= 1'b1;
					tmr_done[k] <= 1'b0;
				end
				else if (!act[FN_TIMER1 + k])
				begin
					tmr_run[k] <= 1'b0;
					tmr_done[k] <= 1'b0;
				end
				else if (tmr_run[k] && ms_tick)
				begin
					if (tmr_cnt[k] <= TIMER_W'(1))
					begin
						tmr_run[k] <= 1'b0;
						tmr_done[k] <= 1'b1; // RULE_08
					end
					else
						tmr_cnt[k] <= tmr_cnt[k] - 1'b1;
				end
			end
		end
	end

	assign timer1_done_o = tmr_done[0];
	assign timer2_done_o = tmr_done[1];

	// A pulse arriving with the clear is kept, so the count restarts at one
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pulse_count_o <= '0;
			cleared_count_display_o <= 1'b0;
		end
		else if (rise[FN_CNT_CLR])
		begin
			pulse_count_o <= rise[FN_PULSE_CNT] ? COUNT_W'(1) : '0; // RULE_18
			cleared_count_display_o <= ~rise[FN_PULSE_CNT];
		end
		else if (rise[FN_PULSE_CNT] && pulse_count_o != COUNT_MAX) // RULE_22
		begin
			pulse_count_o <= pulse_count_o + 1'b1; // RULE_17
			cleared_count_display_o <= 1'b0;
		end
	end

endmodule // input_terminal_function_decoder

// *** input_term_pkg.sv ***
// Constants, function codes and timing for the input terminal function decoder
// Functional notes
// RULE_01 - Each of six terminals has its own function code, range 00 to 32.
// RULE_02 - Code 01 run, 02 forward, 03 reverse, 04 stop, 05 direction toggle.
// RULE_03 - Operator assigns code 07 or 08 to some terminal to use jog.
// RULE_04 - Jog ignores all other commands and uses acceleration time IV; closed_loop_ctrl_o (code 25) is not gated by jog.
// RULE_05 - Releasing jog stops the output at once, with no ramp.
// RULE_06 - Jog is accepted only while stopped, ignored while running.
// RULE_07 - Jog frequency 0.0 to 1000.0 Hz, clamped to lower limit and maximum.
// RULE_08 - Codes 09 and 10 start timer one or two; expiry actuates an output.
// RULE_09 - Code 11 forces the frequency reference to the main setting.
// RULE_10 - Code 12 overheat input, 13 external cut-off fault, 14 fault reset.
// RULE_11 - Codes 17 and 18 select one of four acceleration times.
// RULE_12 - Codes 19, 20, 21, 26 address one of sixteen preset speeds.
// RULE_13 - Codes 22, 23, 24 pick high, medium, low speed; highest wins.
// RULE_14 - Code 25 enables closed-loop control, effective only while running.
// RULE_15 - Codes 27, 28 step frequency; held input steps fast then uniformly.
// RULE_16 - Code 29 permits the wobble frequency function.
// RULE_17 - Code 31 counts every pulse up to 250 Hz.
// RULE_18 - Code 32 clears the count, shows the cleared count, restarts counting.
// RULE_19 - Three-wire: buttons act on their effective edges.
// RULE_20 - Operator selects terminal source and codes 02, 03, 04 on terminals a-c.
// RULE_21 - Three-wire: forward edge runs forward, reverse edge reverse, stop opening stops.
// RULE_22 - Pulse counter saturates at 65535 until reset.
// RULE_23 - Every terminal is synchronised and debounced before decoding.
package input_term_pkg;

	localparam int NUM_TERMS = 6;
	localparam int FUNC_W = 6;
	localparam int NUM_CODES = 33;
	localparam int FREQ_W = 14;
	localparam int COUNT_W = 16;
	localparam int TIMER_W = 16;

	localparam logic [FUNC_W-1:0] FN_MAX = 6'h20;
	localparam logic [FUNC_W-1:0] FN_RUN = 6'h01;
	localparam logic [FUNC_W-1:0] FN_CW = 6'h02;
	localparam logic [FUNC_W-1:0] FN_CCW = 6'h03;
	localparam logic [FUNC_W-1:0] FN_STOP = 6'h04;
	localparam logic [FUNC_W-1:0] FN_TOGGLE = 6'h05;
	localparam logic [FUNC_W-1:0] FN_JOG = 6'h06;
	localparam logic [FUNC_W-1:0] FN_JOG_CW = 6'h07;
	localparam logic [FUNC_W-1:0] FN_JOG_CCW = 6'h08;
	localparam logic [FUNC_W-1:0] FN_TIMER1 = 6'h09;
	localparam logic [FUNC_W-1:0] FN_FORCE_MAIN = 6'h0b;
	localparam logic [FUNC_W-1:0] FN_OVERHEAT = 6'h0c;
	localparam logic [FUNC_W-1:0] FN_EXT_FAULT = 6'h0d;
	localparam logic [FUNC_W-1:0] FN_FAULT_RST = 6'h0e;
	localparam logic [FUNC_W-1:0] FN_ACC_SEL0 = 6'h11;
	localparam logic [FUNC_W-1:0] FN_ACC_SEL1 = 6'h12;
	localparam logic [FUNC_W-1:0] FN_SEG0 = 6'h13;
	localparam logic [FUNC_W-1:0] FN_SEG1 = 6'h14;
	localparam logic [FUNC_W-1:0] FN_SEG2 = 6'h15;
	localparam logic [FUNC_W-1:0] FN_HIGH = 6'h16;
	localparam logic [FUNC_W-1:0] FN_MEDIUM = 6'h17;
	localparam logic [FUNC_W-1:0] FN_LOW = 6'h18;
	localparam logic [FUNC_W-1:0] FN_CLOSED_LOOP = 6'h19;
	localparam logic [FUNC_W-1:0] FN_SEG3 = 6'h1a;
	localparam logic [FUNC_W-1:0] FN_UP = 6'h1b;
	localparam logic [FUNC_W-1:0] FN_DOWN = 6'h1c;
	localparam logic [FUNC_W-1:0] FN_WOBBLE = 6'h1d;
	localparam logic [FUNC_W-1:0] FN_PULSE_CNT = 6'h1f;
	localparam logic [FUNC_W-1:0] FN_CNT_CLR = 6'h20;

	localparam logic [1:0] TERM_SRC = 2'h1;
	localparam logic [1:0] ACC_JOG = 2'h3;
	localparam logic [1:0] PRESET_NONE = 2'h0;
	localparam logic [1:0] PRESET_LOW = 2'h1;
	localparam logic [1:0] PRESET_MED = 2'h2;
	localparam logic [1:0] PRESET_HIGH = 2'h3;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;

	localparam int CLK_MHZ = 10;
	localparam int DEBOUNCE_US = 200;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
	localparam int DB_W = 12;
	localparam int MS_CYCLES = 1000 * CLK_MHZ;
	localparam int UD_HOLD_MS = 500;
	localparam int UD_FAST_MS = 20;
	localparam int UD_FAST_STEPS = 25;
	localparam int UD_SLOW_MS = 100;

endpackage : input_term_pkg

// *** contact_bank.sv ***
// Behavioural model of the switches and contacts wired to the six terminals
module contact_bank #(
	parameter int CHATTER = 6
)
(
	input wire logic clk_sys_i, // Bench clock
	input wire logic [5:0] closed_i, // Wanted contact state, bit 0 is terminal a
	output logic [5:0] pin_o // Terminal levels, closed contact reads 1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] settled = 6'h00;
	logic [5:0] moving = 6'h00;
	int left = 0;
	// Real contacts bounce, so every change chatters for a few cycles first
	always @(posedge clk_sys_i)
	begin
		if (closed_i != settled)
		begin
			moving <= closed_i ^ settled;
			settled <= closed_i;
			left <= CHATTER;
		end
		else if (left > 0)
			left <= left - 1;
	end
	assign pin_o = settled ^ (left[0] ? moving : 6'h00);
endmodule // contact_bank

// *** term_decoder_properties.sv ***
// Concurrent checks on the ports of the input terminal decoder
module term_decoder_checker
	import input_term_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
	input wire logic clk_sys_i, // System clock
	input wire logic rst_n_i, // Reset, active low
	input wire logic running_i, // Drive output active
	input wire logic [1:0] command_source_sel_i, // Command source
	input wire logic run_cmd_o, // Run request
	input wire logic jog_active_o, // Jog in progress
	input wire logic output_cut_o, // Immediate stop pulse
	input wire logic [1:0] accel_sel_o, // Acceleration index
	input wire logic [3:0] speed_seg_o, // Segment address
	input wire logic [1:0] preset_speed_sel_o, // Preset speed
	input wire logic force_main_o, // Main setting forced
	input wire logic wobble_en_o, // Wobble permitted
	input wire logic fault_reset_o, // Fault reset pulse
	input wire logic freq_up_step_o, // Up step pulse
	input wire logic freq_down_step_o, // Down step pulse
	input wire logic [COUNT_W-1:0] pulse_count_o, // Counter value
	input wire logic cleared_count_display_o // Cleared count shown
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence jog_held;
		jog_active_o ##1 jog_active_o;
	endsequence
	sequence jog_dropped;
		jog_active_o ##1 !jog_active_o;
	endsequence
	cut_on_release_a: assert property (jog_dropped |-> output_cut_o)
		else $error("jog release without output cut");
	cut_single_a: assert property (output_cut_o |-> $past(jog_active_o) && !jog_active_o
		##1 !output_cut_o)
		else $error("output cut without jog release or too long");
	jog_overrides_a: assert property (jog_held |-> accel_sel_o == ACC_JOG && run_cmd_o
		&& speed_seg_o == 4'h0 && preset_speed_sel_o == PRESET_NONE && !force_main_o
		&& !wobble_en_o)
		else $error("other commands acted during jog");
	jog_when_stopped_a: assert property ($rose(jog_active_o) |-> !$past(running_i)
		&& !$past(run_cmd_o))
		else $error("jog accepted while running");
	fault_reset_pulse_a: assert property (fault_reset_o |=> !fault_reset_o)
		else $error("fault reset longer than one cycle");
	step_pulse_a: assert property (freq_up_step_o || freq_down_step_o |-> !jog_active_o
		&& !(freq_up_step_o && freq_down_step_o) && $past(running_i)
		##1 !freq_up_step_o && !freq_down_step_o)
		else $error("bad frequency step pulse");
	count_step_a: assert property ($changed(pulse_count_o) |-> pulse_count_o == 16'h0001
		|| (pulse_count_o == 16'h0000 && cleared_count_display_o)
		|| (pulse_count_o == $past(pulse_count_o) + 16'h0001
		&& $past(pulse_count_o) != COUNT_MAX))
		else $error("pulse count moved wrongly");
	cleared_shows_zero_a: assert property (cleared_count_display_o
		|-> pulse_count_o == 16'h0000)
		else $error("cleared display with nonzero count");
	run_source_a: assert property ($rose(run_cmd_o) && !jog_active_o
		|-> $past(command_source_sel_i) == TERM_SRC)
		else $error("run started from wrong command source");
endmodule // term_decoder_checker

bind input_terminal_function_decoder term_decoder_checker
	#(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (.*);

// *** tb.sv ***
// Self-checking bench for the input terminal function decoder
module tb import input_term_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic running_i = 1'b0;
	logic [1:0] command_source_sel_i = TERM_SRC;
	logic [5:0] closed = 6'h00;
	logic [FUNC_W-1:0] term_a_func_sel_i, term_b_func_sel_i, term_c_func_sel_i;
	logic [FUNC_W-1:0] term_d_func_sel_i, term_e_func_sel_i, term_f_func_sel_i;
	logic [FREQ_W-1:0] main_freq_setting_i = 14'h01f4, inch_freq_param_i = 14'h2710;
	logic [FREQ_W-1:0] lower_freq_limit_i = 14'h0032, max_freq_i = 14'h1f40;
	logic [FREQ_W-1:0] freq_ii_i = 14'h0258, freq_iii_i = 14'h0190, freq_iv_i = 14'h00c8;
	logic [TIMER_W-1:0] timer1_preset_i = 16'h0005, timer2_preset_i = 16'h0014;
	wire logic input_term_a_i, input_term_b_i, input_term_c_i;
	wire logic input_term_d_i, input_term_e_i, input_term_f_i;
	logic run_cmd_o, ccw_rotation_cmd_o, jog_active_o, output_cut_o, force_main_o;
	logic overheat_fault_o, ext_fault_o, fault_reset_o, closed_loop_ctrl_o, wobble_en_o;
	logic freq_up_step_o, freq_down_step_o, timer1_done_o, timer2_done_o;
	logic cleared_count_display_o;
	logic [1:0] accel_sel_o, preset_speed_sel_o;
	logic [3:0] speed_seg_o;
	logic [FREQ_W-1:0] freq_ref_o;
	logic [COUNT_W-1:0] pulse_count_o;
	logic [15:0] n_cut = 16'h0000, n_frst = 16'h0000, n_up = 16'h0000, n_dn = 16'h0000;
	int err_total = 0;
	int n_compared = 0;

	// Millisecond tick shortened so timers and stepping fit the run
	input_terminal_function_decoder #(.MS_TICK_CYCLES(10)) DUT (.*);
	contact_bank bank (.clk_sys_i(clk_sys_i), .closed_i(closed), .pin_o({input_term_f_i,
		input_term_e_i, input_term_d_i, input_term_c_i, input_term_b_i, input_term_a_i}));

	initial
	begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
	begin
		if (rst_n_i)
		begin
			n_cut <= n_cut + 16'(output_cut_o);
			n_frst <= n_frst + 16'(fault_reset_o);
			n_up <= n_up + 16'(freq_up_step_o);
			n_dn <= n_dn + 16'(freq_down_step_o);
		end
	end

	task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic codes(input logic [FUNC_W-1:0] a, b, c, d, e, f);
		term_a_func_sel_i <= a;
		term_b_func_sel_i <= b;
		term_c_func_sel_i <= c;
		term_d_func_sel_i <= d;
		term_e_func_sel_i <= e;
		term_f_func_sel_i <= f;
	endtask

	// Waits out contact chatter, synchroniser and the 2000-cycle filter
	task automatic apply(input logic [5:0] p);
		closed <= p;
		repeat (2030) @(posedge clk_sys_i);
	endtask

	task automatic preset(input logic [5:0] p, input logic [1:0] s, input logic [13:0] f);
		apply(p);
		check("preset", s, preset_speed_sel_o);
		check("force", p[3], force_main_o);
		check("freq", f, freq_ref_o);
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (140000) @(posedge clk_sys_i);
		err_total++;
		conclude();
	end

	initial
	begin
		codes(FN_RUN, FN_TOGGLE, 6'h00, 6'h00, 6'h00, 6'h00);
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		check("run", 0, run_cmd_o);
		check("count", 0, pulse_count_o);
		apply(6'h01);
		check("run", 1, run_cmd_o);
		check("dir", 0, ccw_rotation_cmd_o);
		apply(6'h03);
		check("dir", 1, ccw_rotation_cmd_o);
		apply(6'h00);
		check("run", 0, run_cmd_o);
		command_source_sel_i <= 2'h0;
		apply(6'h01);
		check("run", 0, run_cmd_o);
		apply(6'h00);
		command_source_sel_i <= TERM_SRC;
		done("two wire");
		codes(FN_RUN, 6'h00, FN_OVERHEAT, FN_EXT_FAULT, FN_FAULT_RST, 6'h00);
		apply(6'h04);
		check("heat", 1, overheat_fault_o);
		apply(6'h05);
		check("run", 0, run_cmd_o);
		apply(6'h08);
		check("heat", 0, overheat_fault_o);
		check("cutoff", 1, ext_fault_o);
		apply(6'h10);
		check("cutoff", 0, ext_fault_o);
		check("fault reset", 1, n_frst);
		apply(6'h00);
		closed <= 6'h04;
		repeat (300) @(posedge clk_sys_i);
		apply(6'h00);
		check("heat", 0, overheat_fault_o);
		done("faults");
		codes(FN_SEG0, FN_SEG1, FN_SEG2, FN_SEG3, FN_ACC_SEL0, FN_ACC_SEL1);
		for (int i = 0; i < 4; i++)
		begin
			apply({2'(i), 4'(i * 5)});
			check("accel", 16'(i), accel_sel_o);
			check("segment", 16'(i * 5), speed_seg_o);
		end
		apply(6'h00);
		done("selectors");
		codes(FN_HIGH, FN_MEDIUM, FN_LOW, FN_FORCE_MAIN, FN_CLOSED_LOOP, FN_WOBBLE);
		preset(6'h07, PRESET_HIGH, freq_ii_i);
		preset(6'h06, PRESET_MED, freq_iii_i);
		preset(6'h04, PRESET_LOW, freq_iv_i);
		preset(6'h0c, PRESET_LOW, main_freq_setting_i);
		preset(6'h00, PRESET_NONE, main_freq_setting_i);
		running_i <= 1'b1;
		apply(6'h30);
		check("closed loop", 1, closed_loop_ctrl_o);
		check("wobble", 1, wobble_en_o);
		apply(6'h00);
		check("wobble", 0, wobble_en_o);
		running_i <= 1'b0;
		done("speeds");
		codes(FN_JOG_CW, FN_JOG_CCW, FN_HIGH, FN_JOG, 6'h00, 6'h00);
		apply(6'h01);
		check("jog", 1, jog_active_o);
		check("accel", ACC_JOG, accel_sel_o);
		check("freq", max_freq_i, freq_ref_o);
		check("dir", 0, ccw_rotation_cmd_o);
		apply(6'h05);
		check("preset", PRESET_NONE, preset_speed_sel_o);
		check("freq", max_freq_i, freq_ref_o);
		apply(6'h04);
		check("jog", 0, jog_active_o);
		check("cut", 1, n_cut);
		check("freq", freq_ii_i, freq_ref_o);
		apply(6'h00);
		inch_freq_param_i <= 14'h000a;
		apply(6'h02);
		check("dir", 1, ccw_rotation_cmd_o);
		check("freq", lower_freq_limit_i, freq_ref_o);
		apply(6'h00);
		check("cut", 2, n_cut);
		apply(6'h08);
		check("jog", 1, jog_active_o);
		apply(6'h00);
		running_i <= 1'b1;
		apply(6'h01);
		check("jog", 0, jog_active_o);
		apply(6'h00);
		done("jog");
		codes(6'h00, 6'h00, 6'h00, 6'h00, FN_UP, FN_DOWN);
		apply(6'h10);
		apply(6'h00);
		check("up", 1, n_up);
		apply(6'h20);
		apply(6'h00);
		check("down", 1, n_dn);
		// Held about 710 ticks: first step, hold step, then fast steps
		closed <= 6'h10;
		repeat (7100) @(posedge clk_sys_i);
		apply(6'h00);
		check("up held", 16'(3 + (700 - UD_HOLD_MS) / UD_FAST_MS), n_up);
		running_i <= 1'b0;
		done("up down");
		codes(FN_TIMER1, 6'h0a, 6'h00, 6'h00, 6'h00, 6'h00);
		apply(6'h03);
		repeat (40) @(posedge clk_sys_i);
		check("timer1", 1, timer1_done_o);
		check("timer2", 0, timer2_done_o);
		repeat (200) @(posedge clk_sys_i);
		check("timer2", 1, timer2_done_o);
		apply(6'h00);
		check("timer1", 0, timer1_done_o);
		done("timers");
		codes(FN_PULSE_CNT, FN_CNT_CLR, 6'h00, 6'h00, 6'h00, 6'h00);
		repeat (2)
		begin
			apply(6'h01);
			apply(6'h00);
		end
		check("count", 2, pulse_count_o);
		apply(6'h02);
		check("count", 0, pulse_count_o);
		check("display", 1, cleared_count_display_o);
		apply(6'h00);
		apply(6'h01);
		check("count", 1, pulse_count_o);
		check("display", 0, cleared_count_display_o);
		apply(6'h00);
		done("counter");
		codes(FN_CW, FN_CCW, FN_STOP, FN_TOGGLE, 6'h00, 6'h00);
		apply(6'h04);
		check("run", 0, run_cmd_o);
		apply(6'h05);
		check("run", 1, run_cmd_o);
		check("dir", 0, ccw_rotation_cmd_o);
		apply(6'h06);
		check("run", 1, run_cmd_o);
		check("dir", 1, ccw_rotation_cmd_o);
		apply(6'h0c);
		check("run", 1, run_cmd_o);
		check("dir", 0, ccw_rotation_cmd_o);
		apply(6'h00);
		check("run", 0, run_cmd_o);
		apply(6'h01);
		check("run", 0, run_cmd_o);
		apply(6'h00);
		done("three wire");
		conclude();
	end
endmodule // tb
